// *** design/srp_port.sv ***
// serial register port: three-wire slave with register file
`timescale 1ns/100ps
module srp_port (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_select_n,
  input wire logic i_serial_data,
  output logic o_serial_data,
  output logic o_serial_data_oe,
  output logic [7:0] o_serial_port_config,
  output logic o_lsb_first
);
  typedef enum logic [2:0] {
    SRP_IDLE = 3'b001,
    SRP_INSTR = 3'b010,
    SRP_DATA = 3'b100
  } srp_state_t;

  // two-stage synchronisers for pins
  logic [1:0] clk_sync_r;
  logic [1:0] sel_sync_r;
  logic [1:0] dat_sync_r;
  logic clk_prev_r;
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      clk_sync_r <= 2'h0;
      sel_sync_r <= 2'h3;
      dat_sync_r <= 2'h0;
      clk_prev_r <= 1'b0;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[0], i_serial_clk};
      sel_sync_r <= {sel_sync_r[0], i_serial_select_n};
      dat_sync_r <= {dat_sync_r[0], i_serial_data};
      clk_prev_r <= clk_sync_r[1];
    end
  end

  logic sel_n;
  logic rise;
  logic fall;
  assign sel_n = sel_sync_r[1];
  assign rise = clk_sync_r[1] & ~clk_prev_r & ~sel_n;
  assign fall = ~clk_sync_r[1] & clk_prev_r & ~sel_n;

  // protocol state
  srp_state_t state_r, state_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_left_r, byte_left_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [4:0] addr_r, addr_nxt;
  logic rd_r, rd_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] regs_r [1:srp_pkg::NUM_REGS-1];
  logic [7:0] regs_nxt [1:srp_pkg::NUM_REGS-1];
  logic sdo_r, sdo_nxt;
  logic oe_r, oe_nxt;
  logic load_pend_r, load_pend_nxt;
  logic [7:0] tx_r, tx_nxt;

  logic lsb;
  logic [7:0] rx_byte;
  logic [7:0] instr;
  logic [7:0] rd_byte;
  logic [4:0] next_addr;
  assign lsb = cfg_r[srp_pkg::CFG_LSB_FIRST_BIT];
  // assemble received byte in current bit order
  assign rx_byte = lsb ? {dat_sync_r[1], shift_r[7:1]} : {shift_r[6:0], dat_sync_r[1]};
  assign instr = rx_byte;
  assign rd_byte = (addr_r == srp_pkg::ADDR_CFG) ? cfg_r : regs_r[addr_r];
  assign next_addr = lsb ? addr_r + 5'h01 : addr_r - 5'h01;

  // next-state logic
  always_comb
  begin
    state_nxt = state_r;
    bit_cnt_nxt = bit_cnt_r;
    byte_left_nxt = byte_left_r;
    shift_nxt = shift_r;
    addr_nxt = addr_r;
    rd_nxt = rd_r;
    cfg_nxt = cfg_r;
    regs_nxt = regs_r;
    sdo_nxt = sdo_r;
    oe_nxt = oe_r;
    load_pend_nxt = load_pend_r;
    tx_nxt = tx_r;
    if (sel_n)
    begin
      state_nxt = SRP_IDLE;
      bit_cnt_nxt = 3'h0;
      byte_left_nxt = 2'h0;
      oe_nxt = 1'b0;
      load_pend_nxt = 1'b0;
    end
    else
    begin
      unique case (state_r)
        SRP_IDLE:
        begin
          state_nxt = SRP_INSTR;
          bit_cnt_nxt = 3'h0;
        end
        SRP_INSTR:
        begin
          if (rise)
          begin
            shift_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'(srp_pkg::INSTR_BITS - 1))
            begin
              state_nxt = SRP_DATA;
              rd_nxt = instr[srp_pkg::INSTR_RW_BIT];
              byte_left_nxt = {instr[srp_pkg::INSTR_CNT_HI_BIT],
                instr[srp_pkg::INSTR_CNT_LO_BIT]};
              addr_nxt = instr[4:0];
              load_pend_nxt = instr[srp_pkg::INSTR_RW_BIT];
            end
          end
        end
        SRP_DATA:
        begin
          // read: drive bit on each fall
          if (fall && rd_r)
          begin
            oe_nxt = 1'b1;
            if (load_pend_r)
            begin
              sdo_nxt = lsb ? rd_byte[0] : rd_byte[7];
              tx_nxt = lsb ? {1'b0, rd_byte[7:1]} : {rd_byte[6:0], 1'b0};
              load_pend_nxt = 1'b0;
            end
            else
            begin
              sdo_nxt = lsb ? tx_r[0] : tx_r[7];
              tx_nxt = lsb ? {1'b0, tx_r[7:1]} : {tx_r[6:0], 1'b0};
            end
          end
          if (rise)
          begin
            shift_nxt = rx_byte;
            bit_cnt_nxt = bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7)
            begin
              // byte complete: write at once, then step address
              if (!rd_r)
              begin
                if (addr_r == srp_pkg::ADDR_CFG)
                begin
                  cfg_nxt = rx_byte;
                  if (rx_byte[srp_pkg::CFG_SOFT_RESET_BIT]
                      || rx_byte[7 - srp_pkg::CFG_SOFT_RESET_BIT])
                  begin
                    for (int i = 1; i < srp_pkg::NUM_REGS; i++)
                      regs_nxt[i] = srp_pkg::REG_RESET;
                    cfg_nxt[srp_pkg::CFG_SOFT_RESET_BIT] = 1'b0;
                    cfg_nxt[7 - srp_pkg::CFG_SOFT_RESET_BIT] = 1'b0;
                  end
                end
                else
                  regs_nxt[addr_r] = rx_byte;
              end
              addr_nxt = next_addr;
              load_pend_nxt = rd_r;
              if (byte_left_r == 2'h0)
              begin
                state_nxt = SRP_IDLE;
                oe_nxt = 1'b0;
                rd_nxt = 1'b0;
              end
              else
                byte_left_nxt = byte_left_r - 2'h1;
            end
          end
        end
      endcase
    end
  end

  // state registers
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_r <= SRP_IDLE;
      bit_cnt_r <= 3'h0;
      byte_left_r <= 2'h0;
      shift_r <= 8'h00;
      addr_r <= 5'h00;
      rd_r <= 1'b0;
      cfg_r <= srp_pkg::CFG_RESET;
      for (int i = 1; i < srp_pkg::NUM_REGS; i++)
        regs_r[i] <= srp_pkg::REG_RESET;
      sdo_r <= 1'b0;
      oe_r <= 1'b0;
      load_pend_r <= 1'b0;
      tx_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_left_r <= byte_left_nxt;
      shift_r <= shift_nxt;
      addr_r <= addr_nxt;
      rd_r <= rd_nxt;
      cfg_r <= cfg_nxt;
      regs_r <= regs_nxt;
      sdo_r <= sdo_nxt;
      oe_r <= oe_nxt;
      load_pend_r <= load_pend_nxt;
      tx_r <= tx_nxt;
    end
  end

  // outputs straight from flops
  assign o_serial_data = sdo_r;
  assign o_serial_data_oe = oe_r;
  assign o_serial_port_config = cfg_r;
  assign o_lsb_first = cfg_r[srp_pkg::CFG_LSB_FIRST_BIT];
endmodule : srp_port

// *** design/srp_pkg.sv ***
// constants for the serial register port
package srp_pkg;
  localparam logic [4:0] ADDR_CFG = 5'h00;
  localparam int CFG_LSB_FIRST_BIT = 6;
  localparam int CFG_SOFT_RESET_BIT = 5;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int NUM_REGS = 32;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int INSTR_BITS = 8;
  localparam int INSTR_RW_BIT = 7;
  localparam int INSTR_CNT_HI_BIT = 6;
  localparam int INSTR_CNT_LO_BIT = 5;
  localparam int SCLK_MAX_MHZ = 15;
endpackage : srp_pkg

// *** tb/srp_port_properties.sv ***
// checker for the serial register port
`timescale 1ns/100ps
module srp_port_properties (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  input wire logic i_serial_clk,
  input wire logic i_serial_select_n,
  input wire logic i_serial_data,
  input wire logic o_serial_data,
  input wire logic o_serial_data_oe,
  input wire logic [7:0] o_serial_port_config,
  input wire logic o_lsb_first
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_arst_n);
  // pin release, edge alignment and register timing
  oe_off_sel_a: assert property (i_serial_select_n [*6] |-> !o_serial_data_oe)
    else $error("data driven while deselected");
  oe_rise_low_a: assert property ($rose(o_serial_data_oe) |-> !i_serial_clk)
    else $error("drive began outside clock low phase");
  bit_fall_a: assert property (o_serial_data_oe && $past(o_serial_data_oe)
    && $changed(o_serial_data) |-> !i_serial_clk)
    else $error("read bit changed outside clock low phase");
  cfg_rise_a: assert property ($changed(o_serial_port_config) |-> $past(i_serial_clk, 2))
    else $error("config changed away from a rising clock");
  cfg_sel_a: assert property ($changed(o_serial_port_config) |-> !$past(i_serial_select_n, 4))
    else $error("config changed while deselected");
  lsb_bit_a: assert property (o_lsb_first == o_serial_port_config[6])
    else $error("bit order flag differs from config bit");
  oe_end_a: assert property ($fell(o_serial_data_oe)
    |-> $past(i_serial_clk, 2) || $past(i_serial_select_n, 3))
    else $error("drive released early");
  abort_a: assert property ($rose(i_serial_select_n) |-> ##[1:6] !o_serial_data_oe)
    else $error("drive kept after deselect");
  // main scenarios reached
  read_c: cover property ($rose(o_serial_data_oe));
  order_c: cover property ($changed(o_lsb_first));
  abort_c: cover property (o_serial_data_oe && i_serial_select_n);
endmodule : srp_port_properties

// *** tb/srp_host.sv ***
// host model acting as serial master
`timescale 1ns/100ps
module srp_host (
  input wire logic i_clk_sys,
  input wire logic i_line,
  output logic o_sclk,
  output logic o_sel_n,
  output logic o_dat,
  output logic o_dat_oe
);
  // idle lines, clock low between frames
  initial
  begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_dat = 1'b0;
    o_dat_oe = 1'b0;
  end
  // one byte, 800 ns clock, line sampled at the rising edge
  // device releases the line at the last rise, so a later sample would miss
  task automatic shift(input logic [7:0] b, input logic lsb, input logic drv,
    output logic [7:0] r);
    int k;
    for (k = 0; k < 8; k++)
    begin
      o_dat <= b[lsb ? k : 7 - k];
      o_dat_oe <= drv;
      repeat (4) @(posedge i_clk_sys);
      r[lsb ? k : 7 - k] = i_line;
      o_sclk <= 1'b1;
      repeat (4) @(posedge i_clk_sys);
      o_sclk <= 1'b0;
    end
  endtask : shift
  // whole cycle: instruction then code+1 data bytes
  task automatic frame(input logic [7:0] ins, input logic lsb, inout logic [31:0] d);
    logic [7:0] r;
    int i;
    o_sel_n <= 1'b0;
    shift(ins, lsb, 1'b1, r);
    for (i = 0; i <= ins[6:5]; i++)
    begin
      shift(d[8*i +: 8], lsb, !ins[7], r);
      d[8*i +: 8] = r;
    end
    repeat (4) @(posedge i_clk_sys);
    o_dat_oe <= 1'b0;
    o_sel_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
  endtask : frame
endmodule : srp_host

// *** tb/testbench.sv ***
// self-checking testbench for the serial register port
`timescale 1ns/100ps
module testbench;
  logic i_clk_sys = 1'b0;
  logic i_arst_n = 1'b0;
  logic sclk, sel_n, h_dat, h_oe, line, o_serial_data, o_serial_data_oe, o_lsb_first;
  logic [7:0] o_serial_port_config;
  logic [31:0] d;
  int errors = 0;
  int samples_checked = 0;
  // clock and shared data line, undriven line flips
  always #50 i_clk_sys = ~i_clk_sys;
  assign line = o_serial_data_oe ? o_serial_data : h_oe ? h_dat : ~o_serial_data;
  srp_host host (.i_clk_sys(i_clk_sys), .i_line(line), .o_sclk(sclk), .o_sel_n(sel_n),
    .o_dat(h_dat), .o_dat_oe(h_oe));
  srp_port dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_serial_clk(sclk),
    .i_serial_select_n(sel_n), .i_serial_data(line), .o_serial_data(o_serial_data),
    .o_serial_data_oe(o_serial_data_oe), .o_serial_port_config(o_serial_port_config),
    .o_lsb_first(o_lsb_first));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic t_msb;
    d = 32'h4433_2211;
    host.frame(8'h69, 1'b0, d);
    host.frame(8'hC8, 1'b0, d);
    check("msb read", 32'h443322, {8'h00, d[23:0]});
    $display("t_msb done");
  endtask : t_msb
  task automatic t_lsb;
    d = 32'h42;
    host.frame(8'h00, 1'b0, d);
    check("config", 32'h142, {o_lsb_first, o_serial_port_config});
    d = 32'hC33C;
    host.frame(8'h24, 1'b1, d);
    host.frame(8'hA4, 1'b1, d);
    check("lsb read", 32'hC33C, {16'h0, d[15:0]});
    $display("t_lsb done");
  endtask : t_lsb
  task automatic t_reset;
    d = 32'h24;
    host.frame(8'h00, 1'b1, d);
    check("order", 32'h0, {o_lsb_first, o_serial_port_config[7:6]});
    host.frame(8'h88, 1'b0, d);
    check("reg08", 32'h0, {24'h0, d[7:0]});
    $display("t_reset done");
  endtask : t_reset
  task automatic t_abort;
    logic [7:0] r;
    host.o_sel_n <= 1'b0;
    host.shift(8'hFF, 1'b0, 1'b1, r);
    host.shift(8'h00, 1'b0, 1'b0, r);
    check("abort read", 32'h0, {24'h0, r});
    host.o_sel_n <= 1'b1;
    repeat (8) @(posedge i_clk_sys);
    d = 32'h77;
    host.frame(8'h01, 1'b0, d);
    host.frame(8'h81, 1'b0, d);
    check("reg01", 32'h77, {24'h0, d[7:0]});
    $display("t_abort done");
  endtask : t_abort
  task automatic finish_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // main sequence after reset
  initial
  begin
    repeat (3) @(posedge i_clk_sys);
    i_arst_n <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
    t_msb();
    t_lsb();
    t_reset();
    t_abort();
    finish_test();
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge i_clk_sys);
    errors++;
    finish_test();
  end
endmodule : testbench
bind srp_port srp_port_properties props (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
  .i_serial_clk(i_serial_clk), .i_serial_select_n(i_serial_select_n),
  .i_serial_data(i_serial_data), .o_serial_data(o_serial_data),
  .o_serial_data_oe(o_serial_data_oe), .o_serial_port_config(o_serial_port_config),
  .o_lsb_first(o_lsb_first));
